/* adcl_sync2.sv */
// shared constants for the converter sequencing block, and a two-stage pin synchroniser
// assumes a single core clock at 10 MHz and a synchronous active-high reset
`timescale 1ns/100ps
package adcl_pkg;
   // ==========================================================
   // clock
   localparam int CLK_PERIOD_NS = 100;
   localparam int CNT_W = 14;
   function automatic int cyc_floor(input int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_floor
   function automatic int cyc_ceil(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_ceil
   // ==========================================================
   // host-side figures, kept for reference by checkers
   localparam int T_CYCLE_MIN_NS = 500;
   localparam int T_CONVERSION_START_IN_HI_MIN_NS = 30;
   localparam int T_CONVERSION_START_IN_LO_MIN_NS = 30;
   localparam int T_RST_LO_MIN_NS = 100;
   // ==========================================================
   // device timing
   localparam int T_CONV_MAX_NS = 340;
   localparam int T_RST_REL_US = 1250;
   localparam int T_NAP_WKUP_NS = 300;
   localparam int T_PWRUP_US = 250;
   localparam int T_CSRDY_F_NS = 5;
   localparam int T_CSRDY_R_NOP_NS = 10;
   localparam int T_CSRDY_R_RW_NS = 70;
   localparam int T_CSSTR_MIN_NS = 12;
   localparam int T_CSSTR_MAX_NS = 40;
   localparam logic [CNT_W-1:0] CONV_CYC = CNT_W'(cyc_floor(T_CONV_MAX_NS));
   localparam int RST_REL_CYC_DEF = cyc_floor(T_RST_REL_US * 1000);
   localparam logic [CNT_W-1:0] NAP_CYC = CNT_W'(cyc_floor(T_NAP_WKUP_NS));
   localparam logic [CNT_W-1:0] PWRUP_CYC = CNT_W'(cyc_floor(T_PWRUP_US * 1000));
   localparam logic [2:0] CSR_NOP_CYC = 3'(cyc_floor(T_CSRDY_R_NOP_NS));
   localparam logic [2:0] CSR_RW_CYC = 3'(cyc_floor(T_CSRDY_R_RW_NS));
   localparam logic [2:0] STR_DLY_CYC = 3'(cyc_ceil(T_CSSTR_MIN_NS));
   // strobe half periods in core cycles for the three divider options
   localparam logic [2:0] HALF_DIV1 = 3'h1;
   localparam logic [2:0] HALF_DIV2 = 3'h2;
   localparam logic [2:0] HALF_DIV4 = 3'h4;
   // pin synchroniser reset image {sclk, cs_n, rst_n, conv}
   localparam logic [3:0] PIN_INIT = 4'h6;
   // ==========================================================
   // types
   typedef enum logic [1:0] {PROTO_SPI, PROTO_SRC_EXT, PROTO_SRC_INT} adcl_proto_t;
   typedef enum logic [1:0] {DIV_1, DIV_2, DIV_4} adcl_div_t;
   typedef enum logic [2:0] {ST_RST, ST_ACQ, ST_CNV, ST_NAP, ST_NAP_WAKE, ST_PD, ST_PD_WAKE}
      adcl_state_t;
endpackage : adcl_pkg

module adcl_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         meta_r <= INIT;
         q <= INIT;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : adcl_sync2

/* adcl_conv_link.sv */
// conversion sequencing, reset/sleep recovery and ready/strobe generation
// assumes host pins arrive asynchronously; mode and divider come from same-clock config logic
`timescale 1ns/100ps
module adcl_conv_link
   import adcl_pkg::*;
#(
   parameter int RST_REL_CYC = adcl_pkg::RST_REL_CYC_DEF
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // host pins
   input wire logic conversion_start_in,
   input wire logic rst_pin_n,
   input wire logic cs_n,
   input wire logic sclk,
   // configuration
   input wire adcl_pkg::adcl_proto_t proto_sel,
   input wire adcl_pkg::adcl_div_t osc_div_sel,
   input wire logic light_sleep_req,
   input wire logic deep_powerdown_mode,
   input wire logic last_op_nop,
   // status
   output logic ready_strobe_out,
   output logic convert_phase,
   output logic converter_busy_flag,
   output logic in_reset
);
   import adcl_pkg::*;

   // ==========================================================
   // pin synchronisation and edges
   logic [3:0] pins_s;
   logic conv_s, rst_n_s, cs_n_s, sclk_s;
   logic conv_prev_r, cs_prev_r, sclk_prev_r;

   adcl_sync2 #(.W(4), .INIT(PIN_INIT)) u_pins (
      .core_clk(core_clk),
      .srst(srst),
      .d({sclk, cs_n, rst_pin_n, conversion_start_in}),
      .q(pins_s)
   );

   assign conv_s = pins_s[0];
   assign rst_n_s = pins_s[1];
   assign cs_n_s = pins_s[2];
   assign sclk_s = pins_s[3];

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         conv_prev_r <= 1'b0;
         cs_prev_r <= 1'b1;
         sclk_prev_r <= 1'b0;
      end
      else
      begin
         conv_prev_r <= conv_s;
         cs_prev_r <= cs_n_s;
         sclk_prev_r <= sclk_s;
      end
   end

   wire conv_rise = conv_s & ~conv_prev_r;
   wire cs_fall = cs_prev_r & ~cs_n_s;
   wire cs_rise = ~cs_prev_r & cs_n_s;
   // launch edge taken as the rising edge of the synchronised serial clock
   wire sclk_launch = sclk_s & ~sclk_prev_r;

   // ==========================================================
   // converter state machine
   localparam logic [CNT_W-1:0] RST_CYC = CNT_W'(RST_REL_CYC);
   adcl_state_t st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   wire cnt_done = (cnt_r == '0);
   wire [CNT_W-1:0] cnt_dec = cnt_r - CNT_W'(1);

   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_done ? cnt_r : cnt_dec;
      if (!rst_n_s)
      begin
         // pin reset wins over every state; the count restarts on release
         st_nxt = ST_RST;
         cnt_nxt = RST_CYC - CNT_W'(1);
      end
      else
      begin
         case (st_r)
            ST_RST:
               if (cnt_done)
                  st_nxt = ST_ACQ;
            ST_ACQ:
               if (deep_powerdown_mode)
                  st_nxt = ST_PD;
               else if (light_sleep_req)
                  st_nxt = ST_NAP;
               else if (conv_rise)
               begin
                  st_nxt = ST_CNV;
                  cnt_nxt = CONV_CYC - CNT_W'(1);
               end
            ST_CNV:
               if (cnt_done)
                  st_nxt = ST_ACQ;
            ST_NAP:
               if (!light_sleep_req)
               begin
                  st_nxt = ST_NAP_WAKE;
                  cnt_nxt = NAP_CYC - CNT_W'(1);
               end
            ST_NAP_WAKE:
               if (cnt_done)
                  st_nxt = ST_ACQ;
            ST_PD:
               if (!deep_powerdown_mode)
               begin
                  st_nxt = ST_PD_WAKE;
                  cnt_nxt = PWRUP_CYC - CNT_W'(1);
               end
            ST_PD_WAKE:
               if (cnt_done)
                  st_nxt = ST_ACQ;
            default:
            begin
               st_nxt = ST_RST;
               cnt_nxt = RST_CYC - CNT_W'(1);
            end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         st_r <= ST_RST;
         cnt_r <= RST_CYC - CNT_W'(1);
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ==========================================================
   // ready / strobe generation
   logic [2:0] csr_cnt_r, csr_cnt_nxt;
   logic [2:0] dly_cnt_r, dly_cnt_nxt;
   logic [2:0] half_cnt_r, half_cnt_nxt;
   logic stb_r, stb_nxt;
   logic run_r, run_nxt;
   logic rvs_nxt;
   logic [2:0] half_sel;

   assign half_sel = (osc_div_sel == DIV_4) ? HALF_DIV4 :
                     (osc_div_sel == DIV_2) ? HALF_DIV2 : HALF_DIV1;
   wire acq_ready = (st_nxt == ST_ACQ);

   always_comb
   begin
      csr_cnt_nxt = (csr_cnt_r == 3'h0) ? csr_cnt_r : csr_cnt_r - 3'h1;
      dly_cnt_nxt = (dly_cnt_r == 3'h0) ? dly_cnt_r : dly_cnt_r - 3'h1;
      half_cnt_nxt = half_cnt_r;
      stb_nxt = stb_r;
      run_nxt = run_r;
      if (cs_rise)
         csr_cnt_nxt = (last_op_nop ? CSR_NOP_CYC : CSR_RW_CYC) - 3'h1;
      if (cs_fall)
      begin
         stb_nxt = 1'b0;
         run_nxt = 1'b0;
         dly_cnt_nxt = STR_DLY_CYC - 3'h1;
      end
      else if (!cs_n_s && proto_sel == PROTO_SRC_EXT)
      begin
         if (sclk_launch)
            stb_nxt = ~stb_r;
      end
      else if (!cs_n_s && proto_sel == PROTO_SRC_INT)
      begin
         if (!run_r && dly_cnt_r == 3'h0)
         begin
            run_nxt = 1'b1;
            stb_nxt = 1'b1;
            half_cnt_nxt = half_sel - 3'h1;
         end
         else if (run_r && half_cnt_r == 3'h0)
         begin
            // equal reload for both phases keeps the duty cycle at one half
            stb_nxt = ~stb_r;
            half_cnt_nxt = half_sel - 3'h1;
         end
         else if (run_r)
            half_cnt_nxt = half_cnt_r - 3'h1;
      end
      if (st_nxt == ST_RST)
         rvs_nxt = 1'b0;
      else if (cs_n_s)
         rvs_nxt = (csr_cnt_nxt == 3'h0) ? acq_ready : 1'b0;
      else if (proto_sel == PROTO_SPI)
         rvs_nxt = 1'b0;
      else
         rvs_nxt = stb_nxt;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         csr_cnt_r <= 3'h0;
         dly_cnt_r <= 3'h0;
         half_cnt_r <= 3'h0;
         stb_r <= 1'b0;
         run_r <= 1'b0;
      end
      else
      begin
         csr_cnt_r <= csr_cnt_nxt;
         dly_cnt_r <= dly_cnt_nxt;
         half_cnt_r <= half_cnt_nxt;
         stb_r <= stb_nxt;
         run_r <= run_nxt;
      end
   end

   // ==========================================================
   // registered outputs
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         ready_strobe_out <= 1'b0;
         convert_phase <= 1'b0;
         converter_busy_flag <= 1'b1;
         in_reset <= 1'b1;
      end
      else
      begin
         ready_strobe_out <= rvs_nxt;
         convert_phase <= (st_nxt == ST_CNV);
         converter_busy_flag <= ~acq_ready;
         in_reset <= (st_nxt == ST_RST);
      end
   end
endmodule : adcl_conv_link

/* adcl_props.sv */
// port checker for the converter sequencing block
// assumes bind onto adcl_conv_link; one core clock, srst synchronous
`timescale 1ns/100ps
module adcl_props
   import adcl_pkg::*;
#(
   parameter int RST_REL_CYC = 20
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // host pins and configuration
   input wire logic conversion_start_in,
   input wire logic rst_pin_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire adcl_pkg::adcl_proto_t proto_sel,
   input wire adcl_pkg::adcl_div_t osc_div_sel,
   input wire logic light_sleep_req,
   input wire logic deep_powerdown_mode,
   input wire logic last_op_nop,
   // status
   input wire logic ready_strobe_out,
   input wire logic convert_phase,
   input wire logic converter_busy_flag,
   input wire logic in_reset
);
   import adcl_pkg::*;
   // ====================
   // sequences
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   sequence acq_idle_s;
      !converter_busy_flag && !in_reset && !light_sleep_req && !deep_powerdown_mode;
   endsequence
   sequence conv_run_s;
      convert_phase [*3] ##1 !convert_phase;
   endsequence
   // ====================
   // assertions
   conv_start_a: assert property (acq_idle_s ##0 $rose(conversion_start_in) |-> ##3 conv_run_s)
      else $error("conversion start not taken");
   rel_ready_a: assert property ($fell(in_reset) && cs_n |-> ready_strobe_out)
      else $error("ready low on reset exit");
   nap_wake_a: assert property ($fell(light_sleep_req) && converter_busy_flag && !in_reset
      && !convert_phase && !deep_powerdown_mode |-> ##[1:5] !converter_busy_flag)
      else $error("light sleep wake too slow");
   spi_fall_a: assert property (proto_sel == PROTO_SPI && $fell(cs_n)
      |-> ##[1:3] !ready_strobe_out) else $error("ready not pulled low");
   cs_rise_a: assert property ($rose(cs_n) ##1 (cs_n && !converter_busy_flag) [*4]
      |-> ready_strobe_out) else $error("ready not back after select");
   busy_show_a: assert property (cs_n [*6] |-> ready_strobe_out == !converter_busy_flag)
      else $error("ready differs from busy state");
   int_div2_a: assert property (proto_sel == PROTO_SRC_INT && osc_div_sel == DIV_2 && !cs_n
      && $rose(ready_strobe_out) |=> ready_strobe_out ##1 !ready_strobe_out)
      else $error("strobe half period wrong");
   ext_toggle_a: assert property (proto_sel == PROTO_SRC_EXT && !cs_n && $rose(sclk)
      |-> ##[2:3] $changed(ready_strobe_out)) else $error("strobe missed launch edge");
endmodule : adcl_props

bind adcl_conv_link adcl_props #(.RST_REL_CYC(RST_REL_CYC)) u_adcl_props (
   .core_clk(core_clk),
   .srst(srst),
   .conversion_start_in(conversion_start_in),
   .rst_pin_n(rst_pin_n),
   .cs_n(cs_n),
   .sclk(sclk),
   .proto_sel(proto_sel),
   .osc_div_sel(osc_div_sel),
   .light_sleep_req(light_sleep_req),
   .deep_powerdown_mode(deep_powerdown_mode),
   .last_op_nop(last_op_nop),
   .ready_strobe_out(ready_strobe_out),
   .convert_phase(convert_phase),
   .converter_busy_flag(converter_busy_flag),
   .in_reset(in_reset)
);

/* adcl_host_mdl.sv */
// host pin model: start, reset, select and serial clock
// assumes the bench calls its tasks; serial clock stands low outside frames
`timescale 1ns/100ps
module adcl_host_mdl (
   // clock
   input wire logic core_clk,
   // host pins
   output logic conversion_start_in,
   output logic rst_pin_n,
   output logic cs_n,
   output logic sclk
);
   // ====================
   // idle pins, also the state at reset release
   initial
   begin
      conversion_start_in = 1'b0;
      rst_pin_n = 1'b1;
      cs_n = 1'b1;
      sclk = 1'b0;
   end
   task automatic pin_reset();
      @(posedge core_clk) rst_pin_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_pin_n <= 1'b1;
   endtask : pin_reset
   // high one cycle, then idle so the next start is 500 ns on
   task automatic convert();
      @(posedge core_clk) conversion_start_in <= 1'b1;
      @(posedge core_clk) conversion_start_in <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask : convert
   task automatic frame(input int n);
      @(posedge core_clk) cs_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      repeat (n)
      begin
         @(posedge core_clk) sclk <= 1'b1;
         repeat (2) @(posedge core_clk);
         sclk <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
      cs_n <= 1'b1;
   endtask : frame
endmodule : adcl_host_mdl

/* adc_conversion_and_link_timing_test.sv */
// self-checking bench for adcl_conv_link with a host pin model
// assumes adcl_pkg compiled first; reset-release count shortened to 20
`timescale 1ns/100ps
module adc_conversion_and_link_timing_test
   import adcl_pkg::*;
;
   logic core_clk, srst, last_op_nop, light_sleep_req, deep_powerdown_mode;
   adcl_proto_t proto_sel;
   adcl_div_t osc_div_sel;
   logic conversion_start_in, rst_pin_n, cs_n, sclk;
   logic ready_strobe_out, convert_phase, converter_busy_flag, in_reset;
   int errors, cmp_count, cyc;
   adcl_conv_link #(.RST_REL_CYC(20)) u_adcl_conv_link (
      .core_clk(core_clk),
      .srst(srst),
      .conversion_start_in(conversion_start_in),
      .rst_pin_n(rst_pin_n),
      .cs_n(cs_n),
      .sclk(sclk),
      .proto_sel(proto_sel),
      .osc_div_sel(osc_div_sel),
      .light_sleep_req(light_sleep_req),
      .deep_powerdown_mode(deep_powerdown_mode),
      .last_op_nop(last_op_nop),
      .ready_strobe_out(ready_strobe_out),
      .convert_phase(convert_phase),
      .converter_busy_flag(converter_busy_flag),
      .in_reset(in_reset)
   );
   adcl_host_mdl u_adcl_host_mdl (
      .core_clk(core_clk),
      .conversion_start_in(conversion_start_in),
      .rst_pin_n(rst_pin_n),
      .cs_n(cs_n),
      .sclk(sclk)
   );
   always #50 core_clk = ~core_clk;
   // ====================
   // helpers
   task automatic chk(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_busy(input logic v, output int n);
      n = 0;
      do
      begin
         @(posedge core_clk) #1;
         n++;
      end while (converter_busy_flag !== v && n < 3000);
   endtask : wait_busy
   // counts ready changes between two sample points of a frame
   task automatic count_chg(input int a, input int b, output int n);
      logic p;
      n = 0;
      repeat (a) @(posedge core_clk) #1;
      p = ready_strobe_out;
      repeat (b - a)
      begin
         @(posedge core_clk) #1;
         n += int'(ready_strobe_out !== p);
         p = ready_strobe_out;
      end
   endtask : count_chg
   task automatic results();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   // ====================
   // scenarios
   task automatic t_conv();
      // two starts at the minimum spacing
      fork
         begin
            u_adcl_host_mdl.convert();
            u_adcl_host_mdl.convert();
         end
         for (int i = 1; i < 13; i++)
         begin
            @(posedge core_clk) #1;
            chk(convert_phase, i inside {[4:6], [9:11]});
            chk(ready_strobe_out, !(i inside {[4:6], [9:11]}));
         end
      join
   endtask : t_conv
   task automatic t_sleep(input logic deep, input int hi);
      int n;
      @(posedge core_clk) light_sleep_req <= !deep;
      deep_powerdown_mode <= deep;
      repeat (2) @(posedge core_clk) #1;
      chk(ready_strobe_out, 1'b0);
      @(posedge core_clk) light_sleep_req <= 1'b0;
      deep_powerdown_mode <= 1'b0;
      wait_busy(1'b0, n);
      chk(n <= hi, 1'b1);
   endtask : t_sleep
   task automatic t_spi(input logic no_operation_cmd);
      int n;
      wait_busy(1'b0, n);
      @(posedge core_clk) last_op_nop <= no_operation_cmd;
      fork
         u_adcl_host_mdl.frame(1);
         begin
            repeat (5) @(posedge core_clk) #1;
            chk(ready_strobe_out, 1'b0);
         end
      join
      repeat (3) @(posedge core_clk) #1;
      chk(ready_strobe_out, 1'b1);
   endtask : t_spi
   task automatic t_link(input adcl_proto_t p, input adcl_div_t d, input int b, input int exp);
      int n;
      @(posedge core_clk) proto_sel <= p;
      osc_div_sel <= d;
      fork
         u_adcl_host_mdl.frame(4);
         count_chg(5, b, n);
      join
      chk(n == exp, 1'b1);
      repeat (6) @(posedge core_clk);
   endtask : t_link
   task automatic t_pinrst();
      int n;
      u_adcl_host_mdl.pin_reset();
      repeat (2) @(posedge core_clk) #1;
      chk(in_reset, 1'b1);
      chk(ready_strobe_out, 1'b0);
      wait_busy(1'b0, n);
      chk(n <= 24, 1'b1);
      chk(ready_strobe_out, 1'b1);
   endtask : t_pinrst
   // ====================
   // main sequence and hang guard
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         results();
      end
   end
   initial
   begin
      int n;
      core_clk = 1'b0;
      srst = 1'b1;
      proto_sel = PROTO_SPI;
      osc_div_sel = DIV_1;
      light_sleep_req = 1'b0;
      deep_powerdown_mode = 1'b0;
      last_op_nop = 1'b0;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      wait_busy(1'b0, n);
      chk(n <= 24, 1'b1);
      chk(ready_strobe_out, 1'b1);
      t_conv();
      t_sleep(1'b0, int'(NAP_CYC) + 2);
      t_sleep(1'b1, int'(PWRUP_CYC) + 2);
      t_spi(1'b1);
      t_spi(1'b0);
      t_link(PROTO_SRC_EXT, DIV_1, 24, 4);
      t_link(PROTO_SRC_INT, DIV_1, 21, 16);
      t_link(PROTO_SRC_INT, DIV_2, 21, 8);
      t_link(PROTO_SRC_INT, DIV_4, 21, 4);
      t_pinrst();
      results();
   end
endmodule : adc_conversion_and_link_timing_test
